// ---- config_word_loader_defines.svh ----
// constants for the configuration word loader
`ifndef CONFIG_WORD_LOADER_DEFINES_SVH
`define CONFIG_WORD_LOADER_DEFINES_SVH

// absolute configuration memory word addresses
`define CWL_WORD_ADDR_W        6
`define CWL_WORD_STATION0      6'h00
`define CWL_WORD_STATION2      6'h02
`define CWL_WORD_CTRL1         6'h0A
`define CWL_WORD_SUBSYS_ID     6'h0B
`define CWL_WORD_SUBSYS_VENDOR 6'h0C
`define CWL_WORD_DEVICE_ID     6'h0D
`define CWL_WORD_VENDOR_ID     6'h0E
`define CWL_WORD_DEV_REV       6'h1E
`define CWL_SECTION_BASE       6'h00

// control word 1 bit positions
`define CWL_BIT_PARITY         14
`define CWL_BIT_FW_BLOCK       11
`define CWL_BIT_PIN_HOLD       6
`define CWL_BIT_PLL_SHUT       4
`define CWL_BIT_PWR_MGMT       3
`define CWL_BIT_DMA_GATE_OFF   2
`define CWL_BIT_LOAD_SUBSYS    1
`define CWL_BIT_LOAD_VENDEV    0
// dynamic device-off enable within the revision word
`define CWL_BIT_DDOFF_ALLOWED  15

// control word 1 hardware default and the illegal vendor code
`define CWL_CTRL1_RESET        16'h202F
`define CWL_VENDOR_INVALID     16'hFFFF

// register byte addresses of the avalon slave
`define CWL_REG_STATUS         4'h0
`define CWL_REG_CTRL1          4'h4
`define CWL_REG_STA_LO         4'h8
`define CWL_REG_STA_HI         4'hC
`define CWL_REG_IDS_SUB        5'h10
`define CWL_REG_IDS_DEV        5'h14
`define CWL_REG_RELOAD         5'h18

`endif

// ---- config_word_loader_pkg.sv ----
// types for the configuration word loader
package config_word_loader_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ISSUE = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_STORE = 5'b01000,
        ST_DONE  = 5'b10000
    } load_state_type;
endpackage : config_word_loader_pkg

// ---- config_word_loader.sv ----
// configuration word loader: fetches hardware words after power-good or reset
// Function
// [RL1] word addresses absolute, offsets section relative
// [RL2] station address from words 0x00-0x02, low-first
// [RL3] image holds unique six-byte station address
// [RL4] control word 1 fetched from word 0x0A
// [RL5] bit 14 parity enable, power-good only
// [RL6] image sets parity enable to one
// [RL7] bit 11 blocks host firmware download
// [RL8] bit 6 holds pins in device-off
// [RL9] pin hold ignored when device-off disabled
// [RL10] bit 4 allows PHY PLL shutdown
// [RL11] bit 3 clear: power management read-only
// [RL12] image sets power management bit
// [RL13] bit 2 disables DMA clock gating
// [RL14] bit 1 loads subsystem identities
// [RL15] bit 0 loads device and vendor identities
// [RL16] word 0x0B into subsystem identifier
// [RL17] word 0x0C into subsystem vendor identifier
// [RL18] word 0x0D into device identifier
// [RL19] word 0x0E into vendor identifier
// [RL20] vendor word 0xFFFF keeps default code
// [RL21] host waits until loading finished
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`include "config_word_loader_defines.svh"

module config_word_loader #(
    parameter logic [15:0] DEF_SUBSYS_ID     = 16'h0000, // arbitrary built-in value
    parameter logic [15:0] DEF_SUBSYS_VENDOR = 16'h1234, // arbitrary built-in value
    parameter logic [15:0] DEF_DEVICE_ID     = 16'h5678, // arbitrary built-in value
    parameter logic [15:0] DEF_VENDOR_ID     = 16'h1234  // arbitrary built-in value
) (
    input  wire logic        mclk_i,               // core clock 200 MHz
    input  wire logic        nrst_i,               // async reset, active low
    input  wire logic        power_good_event_i,   // one-cycle power-good pulse
    input  wire logic        dev_reset_event_i,    // one-cycle device reset pulse
    // configuration memory read port
    output logic [5:0]       mem_addr_o,           // absolute word address
    output logic             mem_rd_o,             // read strobe
    input  wire logic        mem_valid_i,          // read data valid
    input  wire logic [15:0] mem_data_i,           // read data
    // loaded values
    output logic [47:0]      receive_address_slot_zero_o, // station address
    output logic             global_parity_enable_o,      // to error control reg
    output logic             host_fw_download_block_o,    // refuse fw download
    output logic             pin_hold_in_device_off_o,    // keep pins in device-off
    output logic             pll_shutdown_allow_o,        // phy pll may stop
    output logic             pm_read_only_o,              // pm regs read-only, no D3
    output logic             dma_gate_disable_o,          // dma clock gating off
    output logic [15:0]      subsys_id_o,                 // config space
    output logic [15:0]      subsys_vendor_o,             // config space
    output logic [15:0]      device_id_o,                 // config space
    output logic [15:0]      vendor_id_o,                 // config space
    output logic             load_done_o,                 // all words applied
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,          // byte address
    input  wire logic        avs_read,             // read request
    input  wire logic        avs_write,            // write request
    input  wire logic [31:0] avs_writedata,        // write data
    output logic [31:0]      avs_readdata,         // read data
    output logic             avs_waitrequest       // stall
);
    config_word_loader_pkg::load_state_type state_r, state_nxt;
    logic [5:0]  addr_r;
    logic [15:0] ctrl1_r, data_r, rev_r;
    logic [47:0] sta_r;
    logic [15:0] sub_r, subv_r, dev_r, ven_r;
    logic        par_r, pg_pend_r, done_r, rd_r;
    logic [31:0] rdata_r;
    logic        ack_r;

    // next fetch address: skip identity words that are not enabled
    function automatic logic [5:0] next_addr(input logic [5:0] a, input logic [15:0] c);
        logic [5:0] n;
        n = a + 6'h01;
        if (n == `CWL_WORD_STATION2 + 6'h01)
            n = `CWL_WORD_CTRL1;                                         // RL4
        if (n == `CWL_WORD_SUBSYS_ID && !c[`CWL_BIT_LOAD_SUBSYS])
            n = `CWL_WORD_DEVICE_ID;                                     // RL14
        if (n == `CWL_WORD_DEVICE_ID && !c[`CWL_BIT_LOAD_VENDEV])
            n = `CWL_WORD_DEV_REV;                                       // RL15
        if (n == `CWL_WORD_VENDOR_ID + 6'h01)
            n = `CWL_WORD_DEV_REV;
        return n;
    endfunction : next_addr

    wire start_w = power_good_event_i | dev_reset_event_i | 
                   (avs_write & ~avs_waitrequest & (avs_address == `CWL_REG_RELOAD) & avs_writedata[0]);
    wire last_w  = (addr_r == `CWL_WORD_DEV_REV);
    // the skip decision right after word 0x0A must see the word just fetched, not the old copy
    wire [15:0] skip_ctl_w = (addr_r == `CWL_WORD_CTRL1) ? data_r : ctrl1_r; // RL14 RL15
    // all addresses are absolute; offsets would add a section base of zero
    wire [5:0] abs_addr_w = addr_r + `CWL_SECTION_BASE;                  // RL1

    // sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            config_word_loader_pkg::ST_IDLE:  state_nxt = config_word_loader_pkg::ST_ISSUE;
            config_word_loader_pkg::ST_ISSUE: state_nxt = config_word_loader_pkg::ST_WAIT;
            config_word_loader_pkg::ST_WAIT:  if (mem_valid_i) state_nxt = config_word_loader_pkg::ST_STORE;
            config_word_loader_pkg::ST_STORE: state_nxt = last_w ? config_word_loader_pkg::ST_DONE
                                                                 : config_word_loader_pkg::ST_ISSUE;
            config_word_loader_pkg::ST_DONE:  state_nxt = config_word_loader_pkg::ST_DONE;
            default:                          state_nxt = config_word_loader_pkg::ST_IDLE;
        endcase
        if (start_w)
            state_nxt = config_word_loader_pkg::ST_IDLE;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= config_word_loader_pkg::ST_IDLE;
            addr_r  <= `CWL_WORD_STATION0;
            rd_r    <= 1'b0;
            data_r  <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            rd_r    <= (state_nxt == config_word_loader_pkg::ST_ISSUE);
            if (mem_valid_i && state_r == config_word_loader_pkg::ST_WAIT)
                data_r <= mem_data_i;
            if (start_w)
                addr_r <= `CWL_WORD_STATION0;
            else if (state_r == config_word_loader_pkg::ST_STORE && !last_w)
                addr_r <= next_addr(addr_r, skip_ctl_w);
        end
    end

    // power-good must reach the parity copy even though the reload restarts
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            pg_pend_r <= 1'b1;
        else if (power_good_event_i)
            pg_pend_r <= 1'b1;
        else if (state_r == config_word_loader_pkg::ST_STORE && addr_r == `CWL_WORD_CTRL1)
            pg_pend_r <= 1'b0;
    end

    // word capture; identity defaults return when a new load begins
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl1_r <= `CWL_CTRL1_RESET;
            sta_r   <= 48'h0000_0000_0000;
            rev_r   <= 16'h0000;
            par_r   <= 1'b0;
            sub_r   <= DEF_SUBSYS_ID;
            subv_r  <= DEF_SUBSYS_VENDOR;
            dev_r   <= DEF_DEVICE_ID;
            ven_r   <= DEF_VENDOR_ID;
            done_r  <= 1'b0;
        end else if (start_w) begin
            sub_r   <= DEF_SUBSYS_ID;
            subv_r  <= DEF_SUBSYS_VENDOR;
            dev_r   <= DEF_DEVICE_ID;
            ven_r   <= DEF_VENDOR_ID;
            done_r  <= 1'b0;
        end else if (state_r == config_word_loader_pkg::ST_STORE) begin
            unique case (addr_r)
                6'h00: sta_r[15:0]  <= data_r;                           // RL2
                6'h01: sta_r[31:16] <= data_r;                           // RL2
                6'h02: sta_r[47:32] <= data_r;                           // RL2
                `CWL_WORD_CTRL1: begin
                    ctrl1_r <= data_r;                                   // RL4
                    if (pg_pend_r)
                        par_r <= data_r[`CWL_BIT_PARITY];                // RL5
                end
                `CWL_WORD_SUBSYS_ID:     sub_r  <= data_r;               // RL16
                `CWL_WORD_SUBSYS_VENDOR: subv_r <= data_r;               // RL17
                `CWL_WORD_DEVICE_ID:     dev_r  <= data_r;               // RL18
                `CWL_WORD_VENDOR_ID:
                    ven_r <= (data_r == `CWL_VENDOR_INVALID) ? DEF_VENDOR_ID : data_r; // RL19 RL20
                `CWL_WORD_DEV_REV: begin
                    rev_r  <= data_r;
                    done_r <= 1'b1;                                      // RL21
                end
                default: ;
            endcase
        end
    end

    // station address byte order: earlier byte in low half of each word
    assign receive_address_slot_zero_o = sta_r;                          // RL2
    assign global_parity_enable_o      = par_r;                          // RL5
    assign host_fw_download_block_o    = ctrl1_r[`CWL_BIT_FW_BLOCK];     // RL7
    assign pin_hold_in_device_off_o    = ctrl1_r[`CWL_BIT_PIN_HOLD] & rev_r[`CWL_BIT_DDOFF_ALLOWED]; // RL8 RL9
    assign pll_shutdown_allow_o        = ctrl1_r[`CWL_BIT_PLL_SHUT];     // RL10
    assign pm_read_only_o              = ~ctrl1_r[`CWL_BIT_PWR_MGMT];    // RL11
    assign dma_gate_disable_o          = ctrl1_r[`CWL_BIT_DMA_GATE_OFF]; // RL13
    assign subsys_id_o                 = sub_r;
    assign subsys_vendor_o             = subv_r;
    assign device_id_o                 = dev_r;
    assign vendor_id_o                 = ven_r;
    assign load_done_o                 = done_r;
    assign mem_addr_o                  = abs_addr_w;
    assign mem_rd_o                    = rd_r;

    // register read mux; reads of loaded values wait for the load to finish
    wire [31:0] rmux_w =
        (avs_address == `CWL_REG_STATUS)  ? {31'h0000_0000, done_r} :
        (avs_address == `CWL_REG_CTRL1)   ? {16'h0000, ctrl1_r} :
        (avs_address == `CWL_REG_STA_LO)  ? sta_r[31:0] :
        (avs_address == `CWL_REG_STA_HI)  ? {16'h0000, sta_r[47:32]} :
        (avs_address == `CWL_REG_IDS_SUB) ? {subv_r, sub_r} :
        (avs_address == `CWL_REG_IDS_DEV) ? {ven_r, dev_r} : 32'h0000_0000;
    wire need_wait_w = avs_read & ~done_r & (avs_address != `CWL_REG_STATUS); // RL21

    // one-cycle registered answer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= (avs_read | avs_write) & ~ack_r & ~need_wait_w;
            rdata_r <= rmux_w;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rdata_r;
endmodule : config_word_loader

// ---- cwl_mem_model.sv ----
// model of the on-chip configuration word memory
`timescale 1ns/100ps
module cwl_mem_model (
    input  wire logic        mclk_i,  // core clock
    input  wire logic        nrst_i,  // async reset, active low
    input  wire logic        rd_i,    // read strobe
    input  wire logic [5:0]  addr_i,  // absolute word address
    input  wire logic        slow_i,  // stretch each answer
    output logic             valid_o, // data valid pulse
    output logic [15:0]      data_o   // read data
);
    logic [15:0] img [0:63];
    logic [5:0]  a_r;
    logic [2:0]  cnt_r;
    logic        busy_r;
    // outside the valid cycle the data bus toggles, so stale data never looks right
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_r  <= 1'b0;
            valid_o <= 1'b0;
            data_o  <= 16'h0000;
        end else begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            if (rd_i) begin
                busy_r <= 1'b1;
                a_r    <= addr_i;
                cnt_r  <= slow_i ? 3'h4 : 3'h0;
            end else if (busy_r && cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
            else if (busy_r) begin
                busy_r  <= 1'b0;
                valid_o <= 1'b1;
                data_o  <= img[a_r];
            end
        end
    end
endmodule : cwl_mem_model

// ---- config_word_loader_chk.sv ----
// checker: loaded outputs against the words fetched
`timescale 1ns/100ps
module config_word_loader_chk #(
    parameter logic [15:0] DEF_VENDOR_ID = 16'h1234
) (
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic [5:0]  mem_addr_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_valid_i,
    input wire logic [15:0] mem_data_i,
    input wire logic [47:0] receive_address_slot_zero_o,
    input wire logic        host_fw_download_block_o,
    input wire logic        pin_hold_in_device_off_o,
    input wire logic        pll_shutdown_allow_o,
    input wire logic        pm_read_only_o,
    input wire logic        dma_gate_disable_o,
    input wire logic [15:0] subsys_id_o,
    input wire logic [15:0] subsys_vendor_o,
    input wire logic [15:0] device_id_o,
    input wire logic [15:0] vendor_id_o,
    input wire logic        load_done_o,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    logic [15:0] w_r [0:31];
    wire  [15:0] ctl_w = w_r[10];
    // shadow of each word handed over, by absolute address
    always_ff @(posedge mclk_i) if (mem_valid_i) w_r[mem_addr_o[4:0]] <= mem_data_i;
    property p_sta; $rose(load_done_o) |-> receive_address_slot_zero_o == {w_r[2], w_r[1], w_r[0]}; endproperty
    a_sta: assert property (p_sta) else $error("station address wrong");
    property p_bits; $rose(load_done_o) |-> {host_fw_download_block_o, pll_shutdown_allow_o, dma_gate_disable_o}
        == {ctl_w[11], ctl_w[4], ctl_w[2]}; endproperty
    a_bits: assert property (p_bits) else $error("control bits wrong");
    property p_pm; $rose(load_done_o) |-> pm_read_only_o == !ctl_w[3]; endproperty
    a_pm: assert property (p_pm) else $error("power management mode wrong");
    property p_pin; $rose(load_done_o) |-> pin_hold_in_device_off_o == (ctl_w[6] & w_r[30][15]); endproperty
    a_pin: assert property (p_pin) else $error("pin hold wrong");
    property p_sub; $rose(load_done_o) && ctl_w[1] |-> {subsys_vendor_o, subsys_id_o} == {w_r[12], w_r[11]}; endproperty
    a_sub: assert property (p_sub) else $error("subsystem ids wrong");
    property p_ven; $rose(load_done_o) && ctl_w[0] |-> device_id_o == w_r[13]
        && vendor_id_o == ((w_r[14] == 16'hFFFF) ? DEF_VENDOR_ID : w_r[14]); endproperty
    a_ven: assert property (p_ven) else $error("device or vendor id wrong");
    property p_rd; mem_rd_o |=> !mem_rd_o; endproperty
    a_rd: assert property (p_rd) else $error("read strobe too long");
    property p_stall; avs_read && !load_done_o && (avs_address inside {5'h04, 5'h08, 5'h0C, 5'h10, 5'h14})
        |-> avs_waitrequest; endproperty
    a_stall: assert property (p_stall) else $error("read answered during load");
endmodule : config_word_loader_chk
bind config_word_loader config_word_loader_chk #(.DEF_VENDOR_ID(DEF_VENDOR_ID)) chk_i (.mclk_i, .nrst_i,
    .mem_addr_o, .mem_rd_o, .mem_valid_i, .mem_data_i, .receive_address_slot_zero_o, .host_fw_download_block_o,
    .pin_hold_in_device_off_o, .pll_shutdown_allow_o, .pm_read_only_o, .dma_gate_disable_o, .subsys_id_o,
    .subsys_vendor_o, .device_id_o, .vendor_id_o, .load_done_o, .avs_address, .avs_read, .avs_waitrequest);

// ---- tb_top.sv ----
// testbench: loader fed by the memory model, restarted by each trigger
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] DSUB = 16'h0A01, DSVN = 16'h0A02, DDEV = 16'h0A03, DVEN = 16'h0A04; // arbitrary
    logic mclk_i, nrst_i, power_good_event_i, dev_reset_event_i, mem_rd_o, mem_valid_i, slow, load_done_o;
    logic global_parity_enable_o, host_fw_download_block_o, pin_hold_in_device_off_o, pll_shutdown_allow_o;
    logic pm_read_only_o, dma_gate_disable_o, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  mem_addr_o;
    logic [15:0] mem_data_i, subsys_id_o, subsys_vendor_o, device_id_o, vendor_id_o;
    logic [47:0] receive_address_slot_zero_o;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    int          bad_count, check_count, cyc;
    config_word_loader #(.DEF_SUBSYS_ID(DSUB), .DEF_SUBSYS_VENDOR(DSVN), .DEF_DEVICE_ID(DDEV), .DEF_VENDOR_ID(DVEN))
        config_word_loader_i (.mclk_i, .nrst_i, .power_good_event_i, .dev_reset_event_i, .mem_addr_o, .mem_rd_o,
        .mem_valid_i, .mem_data_i, .receive_address_slot_zero_o, .global_parity_enable_o, .host_fw_download_block_o,
        .pin_hold_in_device_off_o, .pll_shutdown_allow_o, .pm_read_only_o, .dma_gate_disable_o, .subsys_id_o,
        .subsys_vendor_o, .device_id_o, .vendor_id_o, .load_done_o, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    cwl_mem_model cwl_mem_model_i (.mclk_i, .nrst_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o), .slow_i(slow),
        .valid_o(mem_valid_i), .data_o(mem_data_i));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // one avalon transfer: hold everything until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= d;
        do @(posedge mclk_i); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk_i);
    endtask : bus
    // image: station bytes 11..66 lead with the vendor part, ids 5B01..5D03
    task automatic img(input logic [15:0] c, input logic [15:0] v, input logic [15:0] rev);
        cwl_mem_model_i.img[0]  = 16'h2211;
        cwl_mem_model_i.img[1]  = 16'h4433;
        cwl_mem_model_i.img[2]  = 16'h6655;
        cwl_mem_model_i.img[10] = c;
        cwl_mem_model_i.img[11] = 16'h5B01;
        cwl_mem_model_i.img[12] = 16'h5C02;
        cwl_mem_model_i.img[13] = 16'h5D03;
        cwl_mem_model_i.img[14] = v;
        cwl_mem_model_i.img[30] = rev;
    endtask : img
    // read ids while loading stalls the bus, then judge every loaded output, parity only after power-good
    task automatic judge(input logic [15:0] c, input logic [15:0] v, input logic [15:0] rev, input logic pg);
        logic [15:0] ev;
        ev = c[0] ? ((v == 16'hFFFF) ? DVEN : v) : DVEN;
        bus(1'b0, 5'h14, 32'h0000_0000, q);
        chk(q, {ev, c[0] ? 16'h5D03 : DDEV});
        chk(load_done_o, 1'b1);
        chk(receive_address_slot_zero_o, 48'h6655_4433_2211);
        chk({host_fw_download_block_o, pll_shutdown_allow_o, pm_read_only_o, dma_gate_disable_o},
            {c[11], c[4], !c[3], c[2]});
        chk(pin_hold_in_device_off_o, c[6] & rev[15]);
        chk({subsys_vendor_o, subsys_id_o}, c[1] ? 32'h5C02_5B01 : {DSVN, DSUB});
        if (pg) chk(global_parity_enable_o, c[14]);
    endtask : judge
    // restart by power-good, device reset or the reload register
    task automatic restart(input int how, input logic [15:0] c, input logic [15:0] v, input logic [15:0] rev);
        img(c, v, rev);
        slow <= (how != 0);
        if (how == 2) bus(1'b1, 5'h18, 32'h0000_0001, q);
        else begin
            power_good_event_i <= (how == 0);
            dev_reset_event_i  <= (how == 1);
            @(posedge mclk_i);
            power_good_event_i <= 1'b0;
            dev_reset_event_i  <= 1'b0;
        end
        while (load_done_o !== 1'b0) @(posedge mclk_i);
        judge(c, v, rev, how == 0);
    endtask : restart
    task automatic s_first();
        chk({vendor_id_o, device_id_o}, {DVEN, DDEV});
        bus(1'b0, 5'h00, 32'h0000_0000, q);
        chk(q[0], 1'b0);
        judge(16'h4849, 16'hFFFF, 16'h8000, 1'b1);
    endtask : s_first
    task automatic s_regs();
        bus(1'b1, 5'h04, 32'h0000_FFFF, q);
        bus(1'b0, 5'h04, 32'h0000_0000, q);
        chk(q[15:0], 16'h003F);
        bus(1'b0, 5'h1C, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
    endtask : s_regs
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (++cyc == 20000) begin
        bad_count++;
        complete_run();
    end
    initial begin
        {nrst_i, power_good_event_i, dev_reset_event_i, slow, avs_read, avs_write} = 6'b0;
        avs_address   = 5'h00;
        avs_writedata = 32'h0000_0000;
        img(16'h4849, 16'hFFFF, 16'h8000);
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        @(posedge mclk_i);
        s_first();
        restart(1, 16'h0016, 16'hABCD, 16'h0000);
        restart(2, 16'h0043, 16'hABCD, 16'h0000);
        restart(0, 16'h003F, 16'hABCD, 16'h8000);
        s_regs();
        complete_run();
    end
endmodule : tb_top
